// File: src/seq_core.sv
`timescale 1ns/10ps
`default_nettype none
module seq_core
  import seq_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // instruction stream
  input wire instr_t instr,
  input wire logic instr_valid,
  // sequencer context
  input wire logic [PCW-1:0] loop_count,
  input wire logic [PCW-1:0] stack_top,
  input wire logic stack_full,
  input wire logic int_pending,
  input wire logic [3:0] fifo_flags,
  input wire logic [7:0] ext_cond,
  // data inputs
  input wire logic [DW-1:0] switch_value_input,
  input wire logic [DW-1:0] input_holding_reg,
  input wire logic [DW-1:0] addr_input_reg,
  input wire logic serial_data_bit,
  // outputs
  output logic [PCW-1:0] pc,
  output logic stack_pop,
  output logic [DW-1:0] addr_output_reg,
  output logic [DW-1:0] io_output_reg,
  output logic [DW-1:0] data_output_reg,
  output logic [7:0] output_control_field,
  output flags_t flags
);
  // register file and datapath state
  logic [DW-1:0] regs_q [NREG];
  logic [DW-1:0] q_q, ach_q, acl_q, bc_q, aor_q, ior_q, dor_q;
  logic [PCW-1:0] pc_q;
  flags_t fl_q;
  logic [7:0] oc_q;

  // operand fetch shared by both sources
  function automatic logic [DW-1:0] fetch(input logic [5:0] s, input logic [DW-1:0] imm);
    logic [DW-1:0] v;
    v = DATA_RESET;
    if (s < 6'h20) v = regs_q[s[4:0]];
    else case (s)
      SEL_ACH: v = ach_q;
      SEL_ACL: v = acl_q;
      SEL_BC: v = bc_q;
      SEL_AOR: v = aor_q;
      SEL_IOR: v = ior_q;
      SEL_DOR: v = dor_q;
      SEL_Q: v = q_q;
      SEL_CONST: v = imm;
      SEL_SWV: v = switch_value_input;
      SEL_IIR: v = input_holding_reg;
      SEL_AIR: v = addr_input_reg;
      default: v = DATA_RESET;
    endcase
    return v;
  endfunction

  // shift fill bit selection, used for both shifted operands
  function automatic logic fill_bit(input logic [3:0] f, input logic [DW-1:0] r, input flags_t fl);
    logic b;
    b = 1'b0;
    case (f)
      FS_CY: b = fl.cy;
      FS_Z: b = fl.z;
      FS_S: b = fl.s;
      FS_ONE: b = 1'b1;
      FS_QREG_LOW_BIT: b = q_q[0];
      FS_QREG_HIGH_BIT: b = q_q[DW-1];
      FS_REG_HIGH_BIT: b = r[DW-1];
      FS_REG_LOW_BIT: b = r[0];
      FS_SERIAL_DATA_BIT: b = serial_data_bit;
      default: b = 1'b0;
    endcase
    return b;
  endfunction

  // condition selection
  wire [4:0] cs = instr.cc_sel;
  wire cond_true = (cs >= CC_EXT0) ? ext_cond[cs[2:0]] :
    (cs == CC_INT) ? int_pending : (cs == CC_BCZ) ? fl_q.block_count_zero_flag :
    (cs == CC_FA) ? fifo_flags[0] : (cs == CC_FB) ? fifo_flags[1] :
    (cs == CC_FC) ? fifo_flags[2] : (cs == CC_FD) ? fifo_flags[3] :
    (cs == CC_Z) ? fl_q.z : (cs == CC_O) ? fl_q.o : (cs == CC_S) ? fl_q.s :
    (cs == CC_CY) ? fl_q.cy : (cs == CC_ACO) ? fl_q.addr_counter_overflow :
    (cs == CC_STACK_FULL_FLAG) ? stack_full : (cs == CC_DOR) ? fl_q.dorf : 1'b0;

  // three-way branch next pc; both opcodes share one path
  wire is_twb = instr_valid && (instr.prog_op == PC_TWB || instr.prog_op == PC_TWBALT);
  wire [PCW-1:0] pc_seq = pc_q + 10'h001;
  wire [PCW-1:0] pc_d = !instr_valid ? pc_q :
    !is_twb ? pc_seq :
    cond_true ? pc_seq :
    (loop_count == 10'h000) ? instr.target :
    stack_top; // relies on a valid stack top

  // datapath operands
  wire two_op = (instr.src2 == SEL_NONE);
  wire [DW-1:0] a = two_op ? fetch(instr.dst1, instr.imm) : fetch(instr.src1, instr.imm);
  wire [DW-1:0] b = two_op ? fetch(instr.src1, instr.imm) : fetch(instr.src2, instr.imm);
  wire cin = instr.use_cp & fl_q.cy;
  wire [DW-1:0] pr = regs_q[instr.pair_reg];

  // arithmetic results; add and subtract carry out, multiply and divide do not
  wire [DW:0] add_r = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
  wire [DW:0] sub_r = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
  wire [2*DW-1:0] mul_r = a * b;
  wire [DW-1:0] div_r = (b == DATA_RESET) ? {DW{1'b1}} : a / b;

  // result mux
  logic [DW-1:0] res, pair_res;
  logic res_cy, res_o, wr;
  always_comb
  begin
    res = DATA_RESET;
    pair_res = pr;
    res_cy = 1'b0;
    res_o = 1'b0;
    wr = instr_valid;
    case (instr.op)
      OP_MOV: res = b;
      OP_ADD:
      begin
        res = add_r[DW-1:0];
        res_cy = add_r[DW];
        res_o = (a[DW-1] == b[DW-1]) && (res[DW-1] != a[DW-1]);
      end
      OP_SUB:
      begin
        res = sub_r[DW-1:0];
        res_cy = sub_r[DW];
        res_o = (a[DW-1] != b[DW-1]) && (res[DW-1] != a[DW-1]);
      end
      OP_MUL: res = mul_r[DW-1:0];
      OP_DIV: res = div_r;
      OP_AND: res = a & b;
      OP_OR: res = a | b;
      OP_XOR: res = a ^ b;
      OP_XNOR: res = ~(a ^ b);
      OP_NEG: res = DATA_RESET - b;
      OP_INC: res = b + 16'h0001;
      OP_DEC: res = b - 16'h0001;
      OP_INV: res = ~b;
      OP_SHL:
      begin
        res = {b[DW-2:0], fill_bit(instr.fill1, b, fl_q)};
        res_cy = b[DW-1];
        pair_res = {pr[DW-2:0], fill_bit(instr.fill2, pr, fl_q)};
      end
      OP_SHR:
      begin
        res = {fill_bit(instr.fill1, b, fl_q), b[DW-1:1]};
        res_cy = b[0];
        pair_res = {fill_bit(instr.fill2, pr, fl_q), pr[DW-1:1]};
      end
      default: wr = 1'b0;
    endcase
  end

  // destination write enables
  wire shift_op = (instr.op == OP_SHL) || (instr.op == OP_SHR);
  wire [5:0] dst_w = (shift_op && two_op && instr.src1 < 6'h20) ? instr.src1 : instr.dst1;
  wire chain = (instr.dst2 != SEL_NONE);
  function automatic logic hit(input logic [5:0] d, input logic [5:0] s);
    return d == s;
  endfunction
  wire w_ach = wr && (hit(dst_w, SEL_ACH) || hit(instr.dst2, SEL_ACH));
  wire w_acl = wr && (hit(dst_w, SEL_ACL) || hit(instr.dst2, SEL_ACL));
  wire w_bc = wr && (hit(dst_w, SEL_BC) || hit(instr.dst2, SEL_BC));
  wire w_dor = wr && hit(dst_w, SEL_DOR);
  wire res_zero = (res == DATA_RESET);

  // flags: zero and sign from result, peripheral flags by destination
  flags_t fl_d;
  always_comb
  begin
    fl_d = fl_q;
    if (wr && instr.op != OP_MOV)
    begin
      fl_d.z = res_zero;
      fl_d.s = res[DW-1];
      fl_d.cy = res_cy;
      fl_d.o = res_o;
    end
    if (w_dor) fl_d.dorf = 1'b1;
    if (w_ach || w_acl) fl_d.addr_counter_overflow = res_cy;
    if (w_bc) fl_d.block_count_zero_flag = res_zero;
  end

  // register file; a loop keeps per-register write logic uniform
  for (genvar i = 0; i < NREG; i++)
  begin : g_reg
    wire w_i = wr && (hit(dst_w, 6'(i)) || (chain && hit(instr.dst2, 6'(i))));
    wire p_i = wr && shift_op && instr.pair_en && (instr.pair_reg == 5'(i));
    always_ff @(posedge clock)
    begin
      if (sys_rst) regs_q[i] <= DATA_RESET;
      else if (w_i) regs_q[i] <= res;
      else if (p_i) regs_q[i] <= pair_res;
    end
  end

  // special registers and sequencer state
  // control fields update in the same cycle as the datapath op
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pc_q <= PC_RESET;
      fl_q <= '0;
      oc_q <= 8'h00;
      q_q <= DATA_RESET;
      ach_q <= DATA_RESET;
      acl_q <= DATA_RESET;
      bc_q <= DATA_RESET;
      aor_q <= DATA_RESET;
      ior_q <= DATA_RESET;
      dor_q <= DATA_RESET;
    end
    else
    begin
      pc_q <= pc_d;
      fl_q <= fl_d;
      if (instr_valid) oc_q <= instr.out_ctl;
      if (wr && (hit(dst_w, SEL_Q) || (chain && hit(instr.dst2, SEL_Q)))) q_q <= res;
      if (w_ach) ach_q <= res;
      if (w_acl) acl_q <= res;
      if (w_bc) bc_q <= res;
      if (wr && (hit(dst_w, SEL_AOR) || hit(instr.dst2, SEL_AOR))) aor_q <= res;
      if (wr && (hit(dst_w, SEL_IOR) || hit(instr.dst2, SEL_IOR))) ior_q <= res;
      if (w_dor || (wr && hit(instr.dst2, SEL_DOR))) dor_q <= res;
    end
  end

  // outputs; the stack is never popped by this block
  assign stack_pop = 1'b0;
  assign pc = pc_q;
  assign addr_output_reg = aor_q;
  assign io_output_reg = ior_q;
  assign data_output_reg = dor_q;
  assign output_control_field = oc_q;
  assign flags = fl_q;

  // checks
  property p_twb_true;
    @(posedge clock) disable iff (sys_rst) is_twb && cond_true |=> pc == $past(pc) + 10'h001;
  endproperty
  a_twb_true: assert property (p_twb_true) else $error("true branch not sequential");
  property p_twb_zero;
    @(posedge clock) disable iff (sys_rst)
      is_twb && !cond_true && loop_count == 10'h000 |=> pc == $past(instr.target);
  endproperty
  a_twb_zero: assert property (p_twb_zero) else $error("zero count target missed");
  property p_twb_stack;
    @(posedge clock) disable iff (sys_rst)
      is_twb && !cond_true && loop_count != 10'h000 |=> pc == $past(stack_top);
  endproperty
  a_twb_stack: assert property (p_twb_stack) else $error("stack top not taken");
  property p_no_pop;
    @(posedge clock) disable iff (sys_rst) is_twb |-> !stack_pop;
  endproperty
  a_no_pop: assert property (p_no_pop) else $error("stack popped on branch");
  property p_xnor;
    @(posedge clock) disable iff (sys_rst)
      instr_valid && instr.op == OP_XNOR && instr.dst1 == SEL_AOR
      |=> addr_output_reg == ~($past(a) ^ $past(b));
  endproperty
  a_xnor: assert property (p_xnor) else $error("xnor result wrong");
  property p_xor;
    @(posedge clock) disable iff (sys_rst)
      instr_valid && instr.op == OP_XOR && instr.dst1 == SEL_IOR
      |=> io_output_reg == ($past(a) ^ $past(b));
  endproperty
  a_xor: assert property (p_xor) else $error("xor result wrong");
  property p_zflag;
    @(posedge clock) disable iff (sys_rst)
      instr_valid && instr.op == OP_AND |=> flags.z == ($past(res) == 16'h0000);
  endproperty
  a_zflag: assert property (p_zflag) else $error("zero flag wrong");
  property p_dorf;
    @(posedge clock) disable iff (sys_rst) w_dor |=> flags.dorf;
  endproperty
  a_dorf: assert property (p_dorf) else $error("output flag not set");
  property p_oc;
    @(posedge clock) disable iff (sys_rst)
      instr_valid |=> output_control_field == $past(instr.out_ctl);
  endproperty
  a_oc: assert property (p_oc) else $error("output control late");
  c_true: cover property (@(posedge clock) is_twb && cond_true);
  c_zero: cover property (@(posedge clock) is_twb && !cond_true && loop_count == 10'h000);
  c_stack: cover property (@(posedge clock) is_twb && !cond_true && loop_count != 10'h000);
  c_chain: cover property (@(posedge clock) instr_valid && chain && wr);
endmodule
`default_nettype wire

// File: src/seq_pkg.sv
package seq_pkg;
  // machine widths
  localparam int DW = 16;
  localparam int PCW = 10;
  localparam int NREG = 32;
  // condition code selector values
  localparam logic [4:0] CC_INT = 5'h00;
  localparam logic [4:0] CC_BCZ = 5'h01;
  localparam logic [4:0] CC_FA = 5'h02;
  localparam logic [4:0] CC_FB = 5'h03;
  localparam logic [4:0] CC_FC = 5'h04;
  localparam logic [4:0] CC_FD = 5'h05;
  localparam logic [4:0] CC_Z = 5'h06;
  localparam logic [4:0] CC_O = 5'h07;
  localparam logic [4:0] CC_S = 5'h08;
  localparam logic [4:0] CC_CY = 5'h09;
  localparam logic [4:0] CC_ACO = 5'h0a;
  localparam logic [4:0] CC_STACK_FULL_FLAG = 5'h0b;
  localparam logic [4:0] CC_DOR = 5'h0c;
  localparam logic [4:0] CC_EXT0 = 5'h10;
  // program control codes
  localparam logic [1:0] PC_NONE = 2'h0;
  localparam logic [1:0] PC_TWB = 2'h1;
  localparam logic [1:0] PC_TWBALT = 2'h2;
  // datapath operations
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_MOV = 5'h01;
  localparam logic [4:0] OP_ADD = 5'h02;
  localparam logic [4:0] OP_SUB = 5'h03;
  localparam logic [4:0] OP_MUL = 5'h04;
  localparam logic [4:0] OP_DIV = 5'h05;
  localparam logic [4:0] OP_AND = 5'h06;
  localparam logic [4:0] OP_OR = 5'h07;
  localparam logic [4:0] OP_XOR = 5'h08;
  localparam logic [4:0] OP_XNOR = 5'h09;
  localparam logic [4:0] OP_NEG = 5'h0a;
  localparam logic [4:0] OP_INC = 5'h0b;
  localparam logic [4:0] OP_DEC = 5'h0c;
  localparam logic [4:0] OP_INV = 5'h0d;
  localparam logic [4:0] OP_SHL = 5'h0e;
  localparam logic [4:0] OP_SHR = 5'h0f;
  // operand selectors: 0..31 general registers, then specials
  localparam logic [5:0] SEL_ACH = 6'h20;
  localparam logic [5:0] SEL_ACL = 6'h21;
  localparam logic [5:0] SEL_BC = 6'h22;
  localparam logic [5:0] SEL_AOR = 6'h23;
  localparam logic [5:0] SEL_IOR = 6'h24;
  localparam logic [5:0] SEL_DOR = 6'h25;
  localparam logic [5:0] SEL_Q = 6'h26;
  localparam logic [5:0] SEL_CONST = 6'h27;
  localparam logic [5:0] SEL_SWV = 6'h28;
  localparam logic [5:0] SEL_IIR = 6'h29;
  localparam logic [5:0] SEL_AIR = 6'h2a;
  localparam logic [5:0] SEL_NONE = 6'h3f;
  // shift fill sources
  localparam logic [3:0] FS_CY = 4'h0;
  localparam logic [3:0] FS_Z = 4'h1;
  localparam logic [3:0] FS_S = 4'h2;
  localparam logic [3:0] FS_ONE = 4'h3;
  localparam logic [3:0] FS_ZERO = 4'h4;
  localparam logic [3:0] FS_QREG_LOW_BIT = 4'h5;
  localparam logic [3:0] FS_QREG_HIGH_BIT = 4'h6;
  localparam logic [3:0] FS_REG_HIGH_BIT = 4'h7;
  localparam logic [3:0] FS_REG_LOW_BIT = 4'h8;
  localparam logic [3:0] FS_SERIAL_DATA_BIT = 4'h9;
  // reset values
  localparam logic [PCW-1:0] PC_RESET = 10'h000;
  localparam logic [DW-1:0] DATA_RESET = 16'h0000;

  // one decoded instruction word
  typedef struct packed {
    logic [1:0] prog_op;      // program control field
    logic [4:0] cc_sel;       // condition selector
    logic [PCW-1:0] target;   // branch target
    logic [4:0] op;           // datapath operation
    logic [5:0] dst1;         // peripheral or register destination
    logic [5:0] dst2;         // register destination of chained form
    logic [5:0] src1;
    logic [5:0] src2;         // SEL_NONE means two-operand form
    logic use_cp;             // carry from previous as third operand
    logic [3:0] fill1;        // fill for shifted register
    logic [3:0] fill2;        // fill for paired register
    logic [4:0] pair_reg;     // paired register of double shift
    logic pair_en;
    logic [DW-1:0] imm;       // immediate constant
    logic [7:0] out_ctl;      // output control field
  } instr_t;

  // status flags
  typedef struct packed {
    logic z;
    logic cy;
    logic s;
    logic o;
    logic addr_counter_overflow;
    logic block_count_zero_flag;
    logic dorf;
  } flags_t;
endpackage

// File: tb/seq_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module three_way_branch_and_logic_ops_tb_top
  import seq_pkg::*;
;
  // general register numbers used as scratch
  localparam logic [5:0] R1 = 6'h01;
  localparam logic [5:0] R2 = 6'h02;
  // clock, reset and instruction stream
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  instr_t instr = '0;
  logic instr_valid = 1'b0;
  // sequencer context and condition inputs
  logic [PCW-1:0] loop_count = '0;
  logic [PCW-1:0] stack_top = '0;
  logic stack_full = 1'b0;
  logic int_pending = 1'b0;
  logic [3:0] fifo_flags = 4'h0;
  logic [7:0] ext_cond = 8'h00;
  // fixed data sources, distinct so a wrong select shows
  logic [DW-1:0] switch_value_input = 16'h5a3c;
  logic [DW-1:0] input_holding_reg = 16'hc3a5;
  logic [DW-1:0] addr_input_reg = 16'h0f1e;
  logic serial_data_bit = 1'b1;
  // design outputs
  logic [PCW-1:0] pc;
  logic stack_pop;
  logic [DW-1:0] addr_output_reg;
  logic [DW-1:0] io_output_reg;
  logic [DW-1:0] data_output_reg;
  logic [7:0] output_control_field;
  flags_t flags;
  // bench state: expected pc, branch expectation, control tag
  logic [PCW-1:0] exp_pc = PC_RESET;
  logic [PCW-1:0] bexp = PC_RESET;
  logic [7:0] oc = 8'h00;
  int n_mismatch = 0;
  int n_compared = 0;

  seq_core dut (
    .clock(clock), .sys_rst(sys_rst), .instr(instr), .instr_valid(instr_valid),
    .loop_count(loop_count), .stack_top(stack_top), .stack_full(stack_full),
    .int_pending(int_pending), .fifo_flags(fifo_flags), .ext_cond(ext_cond),
    .switch_value_input(switch_value_input), .input_holding_reg(input_holding_reg),
    .addr_input_reg(addr_input_reg), .serial_data_bit(serial_data_bit), .pc(pc),
    .stack_pop(stack_pop), .addr_output_reg(addr_output_reg),
    .io_output_reg(io_output_reg), .data_output_reg(data_output_reg),
    .output_control_field(output_control_field), .flags(flags)
  );

  // 40 MHz machine clock
  always #12.5 clock = ~clock;

  // verdict, reached from the main sequence or the watchdog
  task final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // four-state compare, counted
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] expv);
    n_compared++;
    if (got !== expv)
    begin
      $display("unexpected at %0t: got %h want %h", $time, got, expv);
      n_mismatch++;
    end
  endtask

  // instruction with no branch, no second destination and zero fills
  function automatic instr_t mk(input logic [4:0] op, input logic [5:0] d1,
                                input logic [5:0] s1, input logic [5:0] s2,
                                input logic [DW-1:0] imm);
    instr_t i;
    i = '0;
    i.op = op;
    i.dst1 = d1;
    i.dst2 = SEL_NONE;
    i.src1 = s1;
    i.src2 = s2;
    i.imm = imm;
    i.fill1 = FS_ZERO;
    i.fill2 = FS_ZERO;
    return i;
  endfunction

  // one instruction, then an idle cycle; valid drops at the taking edge so it runs once
  task automatic exec(input instr_t i);
    i.out_ctl = oc;
    instr <= i;
    instr_valid <= 1'b1;
    exp_pc = (i.prog_op == PC_NONE) ? exp_pc + 10'h001 : bexp;
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    chk({6'h00, pc}, {6'h00, exp_pc}); // next address or branch result
    chk({8'h00, output_control_field}, {8'h00, oc}); // control field same cycle
    chk({15'h0000, stack_pop}, 16'h0000); // stack left alone
    oc = oc + 8'h01;
    @(posedge clock);
  endtask

  // run an instruction and check the peripheral output it names
  task automatic dp(input instr_t i, input logic [DW-1:0] expv);
    exec(i);
    if (i.dst1 == SEL_DOR)
      chk(data_output_reg, expv);
    else if (i.dst1 == SEL_IOR)
      chk(io_output_reg, expv);
    else if (i.dst1 == SEL_AOR)
      chk(addr_output_reg, expv);
  endtask

  // branch on an internal flag; a false condition with zero count goes to the target
  task automatic fbr(input logic [4:0] c, input logic t);
    instr_t i;
    i = mk(OP_NOP, SEL_NONE, SEL_NONE, SEL_NONE, '0);
    i.prog_op = PC_TWB;
    i.cc_sel = c;
    i.target = 10'h0c3;
    loop_count <= 10'h000;
    bexp = t ? exp_pc + 10'h001 : i.target;
    exec(i);
  endtask

  // both branch opcodes over every input-driven condition and all three paths
  task automatic t_branch;
    logic [4:0] cin [6];
    logic [4:0] c;
    logic val;
    instr_t i;
    cin = '{CC_INT, CC_FA, CC_FB, CC_FC, CC_FD, CC_STACK_FULL_FLAG};
    for (int v = 0; v < 2; v++)
      for (int n = 0; n < 14; n++)
        for (int k = 0; k < 3; k++)
        begin
          c = (n < 6) ? cin[n] : CC_EXT0 + 5'(n - 6);
          val = (k == 0);
          i = mk(OP_NOP, SEL_NONE, SEL_NONE, SEL_NONE, '0);
          i.prog_op = v ? PC_TWBALT : PC_TWB;
          i.cc_sel = c;
          i.target = 10'h155 + 10'(n);
          // only the selected source ever goes true
          int_pending <= val && (c == CC_INT);
          fifo_flags <= (val && c >= CC_FA && c <= CC_FD) ?
            4'(4'h1 << (c - CC_FA)) : 4'h0;
          stack_full <= val && (c == CC_STACK_FULL_FLAG);
          ext_cond <= (val && c >= CC_EXT0) ? 8'(8'h01 << (c - CC_EXT0)) : 8'h00;
          // smallest and largest nonzero counts on the stack path
          loop_count <= (k == 2) ? (v ? 10'h3ff : 10'h001) : 10'h000;
          stack_top <= 10'h2aa - 10'(n); // valid return address
          bexp = (k == 0) ? exp_pc + 10'h001 : (k == 1) ? i.target : 10'h2aa - 10'(n);
          exec(i);
        end
  endtask

  // logic forms, flags and assignment
  task automatic t_data;
    instr_t i;
    dp(mk(OP_MOV, R1, SEL_CONST, SEL_NONE, 16'h1234), '0);
    dp(mk(OP_MOV, SEL_DOR, SEL_CONST, SEL_NONE, 16'h00ff), 16'h00ff);
    dp(mk(OP_XOR, SEL_DOR, R1, SEL_NONE, '0), 16'h12cb); // two-operand xor
    dp(mk(OP_XNOR, SEL_DOR, R1, SEL_NONE, '0), 16'hff00); // two-operand xnor
    chk({13'h0000, flags.z, flags.s, flags.dorf}, 16'h0003); // sign set, output flag
    dp(mk(OP_XOR, SEL_IOR, R1, SEL_CONST, 16'h1234), 16'h0000); // 3-op xor
    chk({13'h0000, flags.z, flags.s, flags.dorf}, 16'h0005); // zero result
    dp(mk(OP_XNOR, SEL_AOR, R1, SEL_CONST, 16'h1234), 16'hffff); // 3-op xnor
    chk({13'h0000, flags.z, flags.s, flags.dorf}, 16'h0003);
    // block counter result zero then nonzero; the constant is always one source
    dp(mk(OP_MOV, SEL_BC, SEL_CONST, SEL_NONE, 16'h0005), '0);
    dp(mk(OP_XOR, SEL_BC, R1, SEL_CONST, 16'h1234), '0);
    chk({15'h0000, flags.block_count_zero_flag}, 16'h0001);
    dp(mk(OP_XOR, SEL_BC, R1, SEL_CONST, 16'h1235), '0);
    chk({15'h0000, flags.block_count_zero_flag}, 16'h0000);
    // carry out of the accumulator half
    dp(mk(OP_MOV, SEL_ACH, SEL_CONST, SEL_NONE, 16'hffff), '0);
    dp(mk(OP_ADD, SEL_ACH, R1, SEL_CONST, 16'hedcc), '0);
    chk({15'h0000, flags.addr_counter_overflow}, 16'h0001);
    // branch on flags left by the add: z, cy, aco and dorf set; s, o and bcz clear
    fbr(CC_Z, 1'b1);
    fbr(CC_S, 1'b0);
    fbr(CC_CY, 1'b1);
    fbr(CC_O, 1'b0);
    fbr(CC_ACO, 1'b1);
    fbr(CC_BCZ, 1'b0);
    fbr(CC_DOR, 1'b1);
    // chained form writes the peripheral and a register together
    i = mk(OP_MOV, SEL_AOR, SEL_SWV, SEL_NONE, '0);
    i.dst2 = R2;
    dp(i, 16'h5a3c);
    dp(mk(OP_MOV, SEL_DOR, R2, SEL_NONE, '0), 16'h5a3c);
    dp(mk(OP_MOV, SEL_Q, SEL_CONST, SEL_NONE, 16'h7e81), '0);
    dp(mk(OP_MOV, SEL_DOR, SEL_Q, SEL_NONE, '0), 16'h7e81);
    dp(mk(OP_MOV, SEL_IOR, SEL_IIR, SEL_NONE, '0), 16'hc3a5);
    dp(mk(OP_MOV, SEL_AOR, SEL_AIR, SEL_NONE, '0), 16'h0f1e);
    dp(mk(OP_MOV, SEL_DOR, SEL_BC, SEL_NONE, '0), 16'h0001);
    dp(mk(OP_MOV, SEL_DOR, SEL_ACH, SEL_NONE, '0), 16'h0000);
    dp(mk(OP_MOV, SEL_ACL, R1, SEL_NONE, '0), '0);
    dp(mk(OP_MOV, SEL_DOR, SEL_ACL, SEL_NONE, '0), 16'h1234);
    dp(mk(OP_MOV, SEL_IOR, SEL_AOR, SEL_NONE, '0), 16'h0f1e);
    dp(mk(OP_MOV, SEL_IOR, SEL_DOR, SEL_NONE, '0), 16'h1234);
    dp(mk(OP_MOV, SEL_AOR, SEL_IOR, SEL_NONE, '0), 16'h1234);
  endtask

  // binary ops on register and constant, then unary ops; register holds 1234
  task automatic t_expr;
    logic [4:0] ops [12];
    logic [DW-1:0] ev [12];
    instr_t i;
    ops = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_XNOR, OP_DIV, OP_MUL,
            OP_NEG, OP_INC, OP_DEC, OP_INV};
    ev = '{16'h1245, 16'h1223, 16'h0010, 16'h1235, 16'h1225, 16'hedda, 16'h0112,
           16'h3574, 16'hedcc, 16'h1235, 16'h1233, 16'hedcb};
    for (int n = 0; n < 12; n++)
      dp(mk(ops[n], SEL_DOR, R1, (n < 8) ? SEL_CONST : SEL_NONE, 16'h0011), ev[n]);
    // carry out of one add feeds the next as its third operand
    i = mk(OP_ADD, SEL_DOR, R1, SEL_CONST, 16'hffff);
    dp(i, 16'h1233);
    i.imm = 16'h0011;
    i.use_cp = 1'b1;
    dp(i, 16'h1246);
  endtask

  // shift by one with several fills; msb 1 and lsb 0 tell the edge bits apart
  task automatic t_shift;
    logic [4:0] so [8];
    logic [3:0] fl [8];
    logic [DW-1:0] ev [8];
    instr_t i;
    // q still holds 7e81 here: its lsb is 1 and its msb 0
    so = '{OP_SHL, OP_SHL, OP_SHL, OP_SHR, OP_SHR, OP_SHR, OP_SHL, OP_SHR};
    fl = '{FS_ONE, FS_ZERO, FS_REG_HIGH_BIT, FS_REG_LOW_BIT, FS_SERIAL_DATA_BIT, FS_ONE, FS_QREG_LOW_BIT, FS_QREG_HIGH_BIT};
    ev = '{16'h2469, 16'h2468, 16'h2469, 16'h491a, 16'hc91a, 16'hc91a, 16'h2469, 16'h491a};
    for (int n = 0; n < 8; n++)
    begin
      dp(mk(OP_MOV, R1, SEL_CONST, SEL_NONE, 16'h9234), '0);
      i = mk(so[n], R1, R1, SEL_NONE, '0);
      i.fill1 = fl[n];
      dp(i, '0);
      dp(mk(OP_MOV, SEL_DOR, R1, SEL_NONE, '0), ev[n]);
    end
    // paired register (r2 holds 5a3c) shifts beside r1 with its own fill
    i = mk(OP_SHL, R1, R1, SEL_NONE, '0);
    i.pair_en = 1'b1;
    i.pair_reg = 5'h02;
    i.fill2 = FS_ONE;
    dp(i, '0);
    dp(mk(OP_MOV, SEL_DOR, R2, SEL_NONE, '0), 16'hb479);
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_branch;
    t_data;
    t_expr;
    t_shift;
    final_report;
  end

  // watchdog: the run needs well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clock);
    n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
